// ---- pkg/addr_unit_pkg.sv ----
package addr_unit_pkg;

  // storage address width, covers every storage location
  localparam int ADDR_W = 15;
  // width of one incrementer slice
  localparam int SLICE_W = 3;
  // number of incrementer slices
  localparam int SLICES = 5;
  // reset value of every address holding register
  localparam logic [14:0] ADDR_RST = 15'h0000;
  // current-address function code on the host command path
  localparam logic [4:0] FN_CUR_ADDR = 5'h03;
  // longest answer time for a status request, in ns
  localparam int ANSWER_MAX_NS = 4000;
  // clock period in ns
  localparam int CLK_PERIOD_NS = 10;
  // longest answer time in cycles, rounded down
  localparam int ANSWER_MAX_CYC = ANSWER_MAX_NS / CLK_PERIOD_NS;

  // transfer sequencing states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FIRST,
    ST_RUN
  } xfer_e;

  // host current-address request and its answer
  typedef struct packed {
    logic req;
    logic [4:0] code;
  } host_req_s;

  typedef struct packed {
    logic reply;
    logic reject;
    logic [14:0] data;
  } host_ans_s;

endpackage

// ---- logic/inc_slice.sv ----
`timescale 1ns/1ns
module inc_slice
  import addr_unit_pkg::*;
#(
  parameter int W = SLICE_W
) (
  input wire logic [W-1:0] d_i, // slice of the address
  input wire logic cin_i, // carry from the lower slice
  input wire logic en_i, // slice enable
  output logic [W-1:0] q_o, // incremented slice
  output logic cout_o // carry to the upper slice
);

  logic [W:0] sum;

  // add the incoming carry; a disabled slice passes its bits and no carry
  always_comb begin
    sum = {1'b0, d_i} + {{W{1'b0}}, cin_i};
    if (!en_i) begin
      sum = {1'b0, d_i};
    end
    q_o = sum[W-1:0];
    cout_o = sum[W];
  end

endmodule

// ---- logic/addr_unit.sv ----
`timescale 1ns/1ns
module addr_unit
  import addr_unit_pkg::*;
(
  input wire logic CORE_CLK_I, // core clock, 100 MHz
  input wire logic RESET_I, // async reset, active high
  input wire logic START_I, // begin a buffered transfer
  input wire logic CYCLE_I, // one-cycle strobe per transfer cycle
  input wire logic [14:0] ACC_I, // first_word_pointer minus one from host
  input wire logic [14:0] STORE_DATA_N_I, // complemented word from memory
  input wire host_req_s HOST_REQ_I, // host function request
  output logic [14:0] STORE_ADDR_O, // address on direct_storage_bus
  output logic CTRL_FETCH_O, // limit word is being fetched
  output logic END_O, // address reached the limit
  output logic BUSY_O, // transfer in progress
  output host_ans_s HOST_ANS_O // answer to the host
);

  ////////////////////////////////////////////////////////////////////////
  // state

  xfer_e state_r, state_nxt; // transfer sequencer
  logic [14:0] addr_r, addr_nxt; // storage address register
  logic [14:0] limit_n_r, limit_n_nxt; // complemented limit word
  logic limit_ok_r, limit_ok_nxt; // limit word captured
  logic [14:0] aux_r, aux_nxt; // auxiliary address register
  logic read_r, read_nxt; // current-address read in progress
  host_ans_s ans_r, ans_nxt; // registered host answer
  logic [14:0] inc_addr; // incrementer output
  logic [SLICES:0] carry; // carries between slices
  logic equal; // comparator result

  ////////////////////////////////////////////////////////////////////////
  // incrementer

  assign carry[0] = 1'b1;
  // five slices chained by carry, every slice enable tied high
  for (genvar g = 0; g < SLICES; g++) begin : g_inc
    inc_slice #(
      .W(SLICE_W)
    ) u_slice (
      .d_i(addr_r[g*SLICE_W +: SLICE_W]),
      .cin_i(carry[g]),
      .en_i(1'b1),
      .q_o(inc_addr[g*SLICE_W +: SLICE_W]),
      .cout_o(carry[g+1])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // comparator on complemented values; only valid once limit is held

  assign equal = limit_ok_r && ((~addr_r) == limit_n_r);

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign STORE_ADDR_O = addr_r;
  assign CTRL_FETCH_O = (state_r == ST_FIRST);
  assign END_O = (state_r == ST_RUN) && equal;
  assign BUSY_O = (state_r != ST_IDLE);
  assign HOST_ANS_O = ans_r;

  ////////////////////////////////////////////////////////////////////////
  // transfer sequencer and address registers

  // next values of the address path; START_I loads the address in ST_IDLE only, equality ends the run, all else moves on the cycle strobe
  always_comb begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    limit_n_nxt = limit_n_r;
    limit_ok_nxt = limit_ok_r;
    unique case (state_r)
      ST_IDLE: begin
        // host path feeds the address only at the start
        if (START_I) begin
          addr_nxt = ACC_I;
          limit_ok_nxt = 1'b0;
          state_nxt = ST_FIRST;
        end
      end
      ST_FIRST: begin
        // memory returns the limit word at the first address
        if (CYCLE_I) begin
          limit_n_nxt = STORE_DATA_N_I;
          limit_ok_nxt = 1'b1;
          addr_nxt = inc_addr;
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        // stop on equality; the limit address itself is not transferred
        if (equal) begin
          state_nxt = ST_IDLE;
        end else if (CYCLE_I) begin
          addr_nxt = inc_addr;
        end
      end
    endcase
  end

  // registers of the address path
  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_r <= ST_IDLE;
      addr_r <= ADDR_RST;
      limit_n_r <= ADDR_RST;
      limit_ok_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      limit_n_r <= limit_n_nxt;
      limit_ok_r <= limit_ok_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // auxiliary register and host current-address read

  // the read freezes the shadow so the host sees a stable value; updates
  // that arrive meanwhile are lost, the next strobe catches up; a lost last step of the run is never caught up
  always_comb begin
    aux_nxt = aux_r;
    read_nxt = read_r;
    ans_nxt = '0;
    if (read_r) begin
      // answer two cycles after the request, well inside the limit
      ans_nxt.reply = 1'b1;
      ans_nxt.data = aux_r;
      read_nxt = 1'b0;
    end else if (HOST_REQ_I.req) begin
      if (HOST_REQ_I.code == FN_CUR_ADDR) begin
        read_nxt = 1'b1;
      end else begin
        ans_nxt.reject = 1'b1;
      end
    end else if (state_nxt != ST_IDLE && (CYCLE_I || START_I)) begin
      // looking at the next state lets the start itself load the shadow
      aux_nxt = addr_nxt;
    end
  end

  // registers of the host read path
  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      aux_r <= ADDR_RST;
      read_r <= 1'b0;
      ans_r <= '0;
    end else begin
      aux_r <= aux_nxt;
      read_r <= read_nxt;
      ans_r <= ans_nxt;
    end
  end

endmodule

// ---- tb/addr_unit_properties.sv ----
`timescale 1ns/1ns
module addr_unit_properties
  import addr_unit_pkg::*;
(
  input wire logic CORE_CLK_I, RESET_I, START_I, CYCLE_I, CTRL_FETCH_O,
  input wire logic END_O, BUSY_O,
  input wire logic [14:0] ACC_I, STORE_DATA_N_I, STORE_ADDR_O,
  input wire host_req_s HOST_REQ_I,
  input wire host_ans_s HOST_ANS_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);
  logic [14:0] lim_r; // limit seen on the fetch strobe
  always_ff @(posedge CORE_CLK_I or posedge RESET_I)
    if (RESET_I) lim_r <= 15'h0;
    else if (CTRL_FETCH_O && CYCLE_I) lim_r <= STORE_DATA_N_I;
  start_load_a: assert property (START_I && !BUSY_O |=>
    CTRL_FETCH_O && STORE_ADDR_O == $past(ACC_I)) else $error("load");
  fetch_rise_a: assert property ($rose(BUSY_O) |-> CTRL_FETCH_O)
    else $error("fetch");
  step_inc_a: assert property (CYCLE_I && BUSY_O && !END_O |=>
    STORE_ADDR_O == 15'($past(STORE_ADDR_O) + 1)) else $error("inc");
  addr_hold_a: assert property (!CYCLE_I && BUSY_O && !END_O |=>
    $stable(STORE_ADDR_O)) else $error("hold");
  end_cmp_a: assert property (BUSY_O && !CTRL_FETCH_O |->
    END_O == (~STORE_ADDR_O == lim_r)) else $error("cmp");
  end_idle_a: assert property (END_O |=> !BUSY_O && !END_O)
    else $error("end");
  read_reply_a: assert property (HOST_REQ_I.req &&
    HOST_REQ_I.code == FN_CUR_ADDR |-> ##2 HOST_ANS_O.reply) else $error("re");
  read_rej_a: assert property (HOST_REQ_I.req &&
    HOST_REQ_I.code != FN_CUR_ADDR |=> HOST_ANS_O.reject) else $error("rj");
endmodule

bind addr_unit addr_unit_properties chk (.*);

// ---- tb/mem_model.sv ----
`timescale 1ns/1ns
module mem_model (
  input wire logic CORE_CLK_I, RESET_I, BUSY_O, CTRL_FETCH_O, END_O,
  input wire logic [14:0] lim, // limit word held at the pointer
  input wire logic [3:0] gap, // extra wait cycles per access
  output logic CYCLE_I, // access done strobe
  output logic [14:0] STORE_DATA_N_I // complemented read word
);
  logic [3:0] cnt_r;
  logic go;
  // no new strobe launched in the end cycle: the channel is stopping anyway
  assign go = BUSY_O && !END_O && cnt_r >= gap;
  always_ff @(posedge CORE_CLK_I or posedge RESET_I)
    if (RESET_I) {cnt_r, CYCLE_I} <= 5'h0;
    else {cnt_r, CYCLE_I} <= {go || !BUSY_O ? 4'h0 : cnt_r + 4'h1, go};
  // other reads carry a pattern built from the wait counter, never a stale word
  assign STORE_DATA_N_I = CTRL_FETCH_O ? ~lim
    : {cnt_r, ~cnt_r, cnt_r, 3'h5};
endmodule

// ---- tb/tb_addr_unit.sv ----
`timescale 1ns/1ns
module tb_addr_unit;
  import addr_unit_pkg::*;
  logic CORE_CLK_I = 1'b0, RESET_I, START_I = 1'b0, CYCLE_I, END_O, BUSY_O;
  logic CTRL_FETCH_O;
  logic [14:0] ACC_I = 15'h0, lim = 15'h0, STORE_DATA_N_I, STORE_ADDR_O;
  logic [3:0] gap = 4'h0;
  host_req_s HOST_REQ_I = '0;
  host_ans_s HOST_ANS_O;
  int error_cnt = 0, n_checks = 0, tick = 0;
  wire clk = CORE_CLK_I;
  addr_unit dut (.*);
  mem_model mem (.*);
  always #5 CORE_CLK_I = ~CORE_CLK_I;
  // a hang ends here; the run needs far fewer cycles
  always @(posedge clk) if (++tick == 3000) begin
    error_cnt++;
    wrap_up();
  end
  task automatic chk(string n, logic [14:0] e, s);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // answer timing is judged by the checker, the data here
  task automatic host_rd(logic [4:0] c, logic [14:0] d);
    @(posedge clk) HOST_REQ_I <= {1'b1, c};
    @(posedge clk) HOST_REQ_I.req <= 1'b0;
    @(posedge clk) #1;
    if (c == FN_CUR_ADDR) chk("data", d, HOST_ANS_O.data);
    repeat (2) @(posedge clk);
  endtask
  // a restart sent while busy must change nothing
  task automatic xfer(logic [14:0] a, l, logic [3:0] g);
    @(posedge clk) {START_I, ACC_I, lim, gap} <= {1'b1, a, l, g};
    for (int n = 0; n < 300 && END_O !== 1'b1; n++) begin
      @(posedge clk) {START_I, ACC_I} <= {n == 1, ~a};
      #1;
    end
    chk("end_addr", l, STORE_ADDR_O);
    host_rd(FN_CUR_ADDR, l);
  endtask
  initial begin
    RESET_I = 1'b1;
    repeat (2) @(posedge clk);
    RESET_I <= 1'b0;
    xfer(15'h00ff, 15'h0101, 4'h0);
    xfer(15'h7ffe, 15'h0001, 4'h3);
    for (int c = 0; c < 5; c++) host_rd(5'(c), 15'h0001);
    wrap_up();
  end
endmodule
